//--- logic/phy_function_interface_ctrl_regs.sv
// ULPI register port with the function and interface control storage.
`timescale 1ns/1ps
`default_nettype none
module phy_function_interface_ctrl_regs (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_ulpi_data,
    input wire logic i_ulpi_stp,
    output logic [7:0] o_ulpi_data,
    output logic o_ulpi_data_oe_n,
    output logic o_ulpi_dir,
    output logic o_ulpi_nxt,
    input wire logic i_ext_vbus_flag_in,
    input wire logic i_vbus_valid_cmp,
    input wire logic i_low_power_exit,
    input wire logic i_serial_exit,
    input wire logic i_uart_exit,
    output logic o_vbus_state,
    output logic o_protect_active,
    output logic o_self_resume_enable,
    output logic o_clock_powered,
    output logic o_low_power_n,
    output logic o_xcvr_reset_pulse,
    output logic [1:0] o_transmit_encoding_select,
    output logic o_termination_select,
    output logic [1:0] o_speed_select,
    output logic o_uart_pins_select,
    output logic o_serial_three_wire_select,
    output logic o_serial_six_wire_select
);
    import phy_regs_pkg::*;

    ulpi_state_t state_r;
    ulpi_state_t state_nxt;
    logic [5:0] addr_r;
    logic [5:0] addr_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] func_r;
    logic [7:0] func_nxt;
    logic [7:0] ifc_r;
    logic [7:0] ifc_nxt;
    logic pulse_r;
    logic pulse_nxt;
    logic vbus_r;
    logic vbus_nxt;
    logic clk_on_r;
    logic clk_on_nxt;
    logic [1:0] sync_out;
    logic ext_flag_s;
    logic vbus_valid_s;
    logic wr_commit;
    logic [7:0] read_value;

    // External flag and comparator arrive from outside the clock domain.
    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_vbus_valid_cmp, i_ext_vbus_flag_in}),
        .o_sync(sync_out)
    );

    assign ext_flag_s = sync_out[0];
    assign vbus_valid_s = sync_out[1];

    // Command decode and turnaround sequencing on the ULPI bus.
    always_comb
    begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        case (state_r)
            ST_IDLE:
            begin
                if (i_ulpi_data[7:6] == CMD_REG_WRITE) // R16
                begin
                    addr_nxt = i_ulpi_data[5:0];
                    state_nxt = ST_WR_ACK;
                end
                else if (i_ulpi_data[7:6] == CMD_REG_READ) // R16
                begin
                    addr_nxt = i_ulpi_data[5:0];
                    state_nxt = ST_RD_ACK;
                end
            end
            ST_WR_ACK:
            begin
                state_nxt = ST_WR_DATA;
            end
            ST_WR_DATA:
            begin
                state_nxt = ST_WR_STOP;
            end
            ST_WR_STOP:
            begin
                if (i_ulpi_stp)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RD_ACK:
            begin
                state_nxt = ST_RD_TURN;
            end
            ST_RD_TURN:
            begin
                state_nxt = ST_RD_DATA;
            end
            ST_RD_DATA:
            begin
                state_nxt = ST_RD_BACK;
            end
            ST_RD_BACK:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_r <= ST_IDLE;
            addr_r <= 6'h00;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
        end
    end

    assign o_ulpi_nxt = (state_r == ST_WR_ACK) || (state_r == ST_WR_DATA)
        || (state_r == ST_RD_ACK);
    assign o_ulpi_dir = (state_r == ST_RD_TURN) || (state_r == ST_RD_DATA);
    assign o_ulpi_data_oe_n = (state_r != ST_RD_DATA); // R16
    assign wr_commit = (state_r == ST_WR_DATA);

    // All three function addresses read the one shared store.
    always_comb
    begin
        if (addr_r == ADDR_FUNC_CTRL)
        begin
            read_value = func_r;
        end
        else if (addr_r == ADDR_FUNC_SET)
        begin
            read_value = func_r;
        end
        else if (addr_r == ADDR_FUNC_CLR)
        begin
            read_value = func_r; // R1
        end
        else if (addr_r == ADDR_IFC_CTRL)
        begin
            read_value = ifc_r;
        end
        else
        begin
            read_value = READ_UNMAPPED;
        end
    end

    always_comb
    begin
        rdata_nxt = rdata_r;
        if (state_r == ST_RD_TURN)
        begin
            rdata_nxt = read_value; // R17
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_ulpi_data = rdata_r;

    // Register writes, with the hardware-driven set and clear events.
    always_comb
    begin
        func_nxt = func_r;
        ifc_nxt = ifc_r;
        pulse_nxt = 1'b0;
        if (i_serial_exit)
        begin
            ifc_nxt[IFC_THREE_BIT] = 1'b0; // R14
            ifc_nxt[IFC_SIX_BIT] = 1'b0; // R14
        end
        if (i_uart_exit)
        begin
            ifc_nxt[IFC_UART_BIT] = 1'b0; // R15
        end
        if (wr_commit)
        begin
            if (addr_r == ADDR_FUNC_CTRL)
            begin
                func_nxt = i_ulpi_data & FUNC_CTRL_STORE_MASK;
                pulse_nxt = i_ulpi_data[FC_XCVR_RESET_BIT];
            end
            else if (addr_r == ADDR_FUNC_SET)
            begin
                func_nxt = (func_r | i_ulpi_data) & FUNC_CTRL_STORE_MASK;
                pulse_nxt = i_ulpi_data[FC_XCVR_RESET_BIT];
            end
            else if (addr_r == ADDR_FUNC_CLR)
            begin
                func_nxt = func_r & ~i_ulpi_data; // R2 R3 R17
            end
            else if (addr_r == ADDR_IFC_CTRL)
            begin
                ifc_nxt = i_ulpi_data;
            end
        end
        if (i_low_power_exit)
        begin
            func_nxt[FC_LOW_POWER_N_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            func_r <= FUNC_CTRL_RESET;
            ifc_r <= IFC_CTRL_RESET; // R5 R9 R12
            pulse_r <= 1'b0;
        end
        else
        begin
            func_r <= func_nxt;
            ifc_r <= ifc_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // VBUS state reporting and serial-mode clock power.
    always_comb
    begin
        logic comp;
        logic serial_any;
        comp = ext_flag_s ^ ifc_r[IFC_INVERT_BIT]; // R8
        serial_any = ifc_r[IFC_UART_BIT] | ifc_r[IFC_THREE_BIT]
            | ifc_r[IFC_SIX_BIT];
        if (ifc_r[IFC_UNQUAL_BIT]) // R6
        begin
            vbus_nxt = comp; // R7
        end
        else
        begin
            vbus_nxt = comp & vbus_valid_s; // R7
        end
        if (!func_r[FC_LOW_POWER_N_BIT])
        begin
            clk_on_nxt = 1'b0; // R11
        end
        else if (serial_any)
        begin
            clk_on_nxt = ifc_r[IFC_CLK_KEEP_N_BIT]; // R10 R12 R13
        end
        else
        begin
            clk_on_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            vbus_r <= 1'b0;
            clk_on_r <= 1'b1;
        end
        else
        begin
            vbus_r <= vbus_nxt;
            clk_on_r <= clk_on_nxt;
        end
    end

    assign o_vbus_state = vbus_r;
    assign o_clock_powered = clk_on_r;
    assign o_protect_active = ~ifc_r[IFC_PROTECT_DIS_BIT]; // R4 R5
    assign o_self_resume_enable = ifc_r[IFC_RESUME_BIT]; // R9
    assign o_uart_pins_select = ifc_r[IFC_UART_BIT]; // R15
    assign o_serial_three_wire_select = ifc_r[IFC_THREE_BIT];
    assign o_serial_six_wire_select = ifc_r[IFC_SIX_BIT];
    assign o_low_power_n = func_r[FC_LOW_POWER_N_BIT];
    assign o_xcvr_reset_pulse = pulse_r;
    assign o_transmit_encoding_select = func_r[FC_ENC_LSB +: 2];
    assign o_termination_select = func_r[FC_TERM_BIT];
    assign o_speed_select = func_r[FC_SPEED_LSB +: 2];
endmodule // phy_function_interface_ctrl_regs
`default_nettype wire

//--- logic/phy_regs_pkg.sv
// Constants shared by the transceiver function and interface control bank.
// Overview of operation
// R1: Clear alias reads back function control contents.
// R2: Clear alias shares the single function storage.
// R3: Writing one clears bit; zero keeps it.
// R4: Bit 7 governs ULPI pin protection circuit.
// R5: Protection active at zero, off at one.
// R6: Bit 6 selects qualifying the VBUS flag.
// R7: Zero combines with comparator; one passes through.
// R8: Bit 5 inverts external VBUS flag input.
// R9: Bit 4 enables self resume, resets one.
// R10: Bit 3 gates only clock, serial modes.
// R11: Clock bit ignored while low power active.
// R12: Reset value zero: clock off in serial.
// R13: Bit 3 one keeps clock powered serially.
// R14: Serial mode exit clears serial select bits; a same-cycle interface control write wins.
// R15: UART exit clears UART select bit; a same-cycle interface control write wins.
// R16: Link uses ULPI register read and write.
// R17: Clear write lands atomically for next read.
`default_nettype none
package phy_regs_pkg;
    localparam logic [5:0] ADDR_FUNC_CTRL = 6'h04;
    localparam logic [5:0] ADDR_FUNC_SET = 6'h05;
    localparam logic [5:0] ADDR_FUNC_CLR = 6'h06;
    localparam logic [5:0] ADDR_IFC_CTRL = 6'h07;
    localparam logic [1:0] CMD_REG_WRITE = 2'h2;
    localparam logic [1:0] CMD_REG_READ = 2'h3;
    localparam int unsigned FC_LOW_POWER_N_BIT = 6;
    localparam int unsigned FC_XCVR_RESET_BIT = 5;
    localparam int unsigned FC_ENC_LSB = 3;
    localparam int unsigned FC_TERM_BIT = 2;
    localparam int unsigned FC_SPEED_LSB = 0;
    localparam int unsigned IFC_PROTECT_DIS_BIT = 7;
    localparam int unsigned IFC_UNQUAL_BIT = 6;
    localparam int unsigned IFC_INVERT_BIT = 5;
    localparam int unsigned IFC_RESUME_BIT = 4;
    localparam int unsigned IFC_CLK_KEEP_N_BIT = 3;
    localparam int unsigned IFC_UART_BIT = 2;
    localparam int unsigned IFC_THREE_BIT = 1;
    localparam int unsigned IFC_SIX_BIT = 0;
    localparam logic [7:0] FUNC_CTRL_RESET = 8'h41;
    localparam logic [7:0] FUNC_CTRL_STORE_MASK = 8'h5F;
    localparam logic [7:0] IFC_CTRL_RESET = 8'h10;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    typedef enum {
        ST_IDLE,
        ST_WR_ACK,
        ST_WR_DATA,
        ST_WR_STOP,
        ST_RD_ACK,
        ST_RD_TURN,
        ST_RD_DATA,
        ST_RD_BACK
    } ulpi_state_t;
endpackage
`default_nettype wire

//--- logic/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    if (WIDTH < 1)
    begin : g_check
        $error("pin_sync needs WIDTH of at least one");
    end

    always_comb
    begin
        out_nxt = out_r;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (s2_r[i] == s3_r[i])
            begin
                out_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end
        else
        begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign o_sync = out_r;
endmodule // pin_sync
`default_nettype wire

//--- verification/ulpi_link_model.sv
// Link-side model that issues ULPI register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
    input wire logic i_clk,
    input wire logic i_nxt,
    input wire logic i_oe_n,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_data,
    output logic o_stp
);
    initial
    begin
        o_data = 8'h00;
        o_stp = 1'b0;
    end
    // Waits a bounded time for the device acknowledge.
    task automatic wait_nxt();
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (!i_nxt && n < 8);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge i_clk);
        o_data <= {2'b10, a};
        wait_nxt();
        o_data <= v;
        @(posedge i_clk);
        o_data <= 8'h00;
        o_stp <= 1'b1;
        @(posedge i_clk);
        o_stp <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        int n;
        v = 8'hXX;
        @(posedge i_clk);
        o_data <= {2'b11, a};
        wait_nxt();
        o_data <= ~o_data;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (i_oe_n && n < 8);
        if (!i_oe_n)
            v = i_rdata;
        o_data <= 8'h00;
    endtask
endmodule // ulpi_link_model
`default_nettype wire

//--- verification/phy_regs_properties.sv
// Concurrent checks on the register bank ports.
`timescale 1ns/1ps
`default_nettype none
module phy_regs_properties (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic o_ulpi_data_oe_n,
    input wire logic o_ulpi_dir,
    input wire logic o_ulpi_nxt,
    input wire logic i_low_power_exit,
    input wire logic i_serial_exit,
    input wire logic i_uart_exit,
    input wire logic o_protect_active,
    input wire logic o_self_resume_enable,
    input wire logic o_clock_powered,
    input wire logic o_low_power_n,
    input wire logic o_uart_pins_select,
    input wire logic o_serial_three_wire_select,
    input wire logic o_serial_six_wire_select
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_turn;
        o_ulpi_dir && o_ulpi_data_oe_n;
    endsequence
    sequence s_rdata;
        o_ulpi_dir && !o_ulpi_data_oe_n;
    endsequence
    sequence s_ack2;
        $rose(o_ulpi_nxt) ##1 o_ulpi_nxt;
    endsequence
    property p_rd_walk;
        $rose(o_ulpi_dir) |-> s_turn ##1 s_rdata ##1 !o_ulpi_dir;
    endproperty
    property p_wr_walk;
        s_ack2 |=> !o_ulpi_nxt && !o_ulpi_dir;
    endproperty
    property p_nxt_dir;
        o_ulpi_nxt |-> !o_ulpi_dir;
    endproperty
    property p_lp_off;
        !$past(o_low_power_n) |-> !o_clock_powered;
    endproperty
    property p_par_on;
        $past(o_low_power_n) && !$past(o_uart_pins_select) &&
            !$past(o_serial_three_wire_select) &&
            !$past(o_serial_six_wire_select) |-> o_clock_powered;
    endproperty
    property p_uart_exit;
        i_uart_exit && !o_ulpi_nxt |=> !o_uart_pins_select;
    endproperty
    property p_ser_exit;
        i_serial_exit && !o_ulpi_nxt |=>
            !o_serial_three_wire_select && !o_serial_six_wire_select;
    endproperty
    property p_lp_exit;
        i_low_power_exit |=> o_low_power_n;
    endproperty
    property p_rst_vals;
        $fell(i_sys_rst) |-> o_self_resume_enable && o_protect_active;
    endproperty
    a_rd_walk: assert property (p_rd_walk)
        else $error("Read turnaround order broken.");
    a_wr_walk: assert property (p_wr_walk)
        else $error("Write acknowledge length wrong.");
    a_nxt_dir: assert property (p_nxt_dir)
        else $error("Acknowledge during turnaround.");
    a_lp_off: assert property (p_lp_off)
        else $error("Clock powered in low power.");
    a_par_on: assert property (p_par_on)
        else $error("Clock off outside serial modes.");
    a_uart_exit: assert property (p_uart_exit)
        else $error("UART select not cleared.");
    a_ser_exit: assert property (p_ser_exit)
        else $error("Serial select not cleared.");
    a_lp_exit: assert property (p_lp_exit)
        else $error("Low power control not set.");
    a_rst_vals: assert property (p_rst_vals)
        else $error("Wrong control values after reset.");
endmodule // phy_regs_properties
bind phy_function_interface_ctrl_regs phy_regs_properties u_props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .o_ulpi_data_oe_n(o_ulpi_data_oe_n), .o_ulpi_dir(o_ulpi_dir),
    .o_ulpi_nxt(o_ulpi_nxt), .i_low_power_exit(i_low_power_exit),
    .i_serial_exit(i_serial_exit), .i_uart_exit(i_uart_exit),
    .o_protect_active(o_protect_active),
    .o_self_resume_enable(o_self_resume_enable),
    .o_clock_powered(o_clock_powered), .o_low_power_n(o_low_power_n),
    .o_uart_pins_select(o_uart_pins_select),
    .o_serial_three_wire_select(o_serial_three_wire_select),
    .o_serial_six_wire_select(o_serial_six_wire_select));
`default_nettype wire

//--- verification/tb_phy_function_interface_ctrl_regs.sv
// Self-checking bench for the function and interface control bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    fail_count++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_phy_function_interface_ctrl_regs;
    import phy_regs_pkg::*;
    logic clk, rst, ext, cmp, lp_x, ser_x, uart_x, stp, oe_n, dir, nxt;
    logic vbus, prot, resume, clk_on, lp_n, pulse, uart;
    logic three, six, term;
    logic [1:0] enc, speed;
    logic [7:0] ldata, pdata, f_m, i_m;
    int fail_count, check_count, pulses, exp_pulses, k;
    phy_function_interface_ctrl_regs u_dut (.i_clk(clk), .i_sys_rst(rst),
        .i_ulpi_data(ldata), .i_ulpi_stp(stp), .o_ulpi_data(pdata),
        .o_ulpi_data_oe_n(oe_n), .o_ulpi_dir(dir), .o_ulpi_nxt(nxt),
        .i_ext_vbus_flag_in(ext), .i_vbus_valid_cmp(cmp),
        .i_low_power_exit(lp_x), .i_serial_exit(ser_x),
        .i_uart_exit(uart_x), .o_vbus_state(vbus), .o_protect_active(prot),
        .o_self_resume_enable(resume), .o_clock_powered(clk_on),
        .o_low_power_n(lp_n), .o_xcvr_reset_pulse(pulse),
        .o_transmit_encoding_select(enc), .o_termination_select(term),
        .o_speed_select(speed), .o_uart_pins_select(uart),
        .o_serial_three_wire_select(three),
        .o_serial_six_wire_select(six));
    ulpi_link_model u_link (.i_clk(clk), .i_nxt(nxt), .i_oe_n(oe_n),
        .i_rdata(pdata), .o_data(ldata), .o_stp(stp));
    function automatic logic [7:0] exp_rd(input logic [5:0] a);
        if (a >= ADDR_FUNC_CTRL && a <= ADDR_FUNC_CLR)
            return f_m;
        return (a == ADDR_IFC_CTRL) ? i_m : 8'h00;
    endfunction
    function automatic logic exp_clk();
        return f_m[6] ? ((|i_m[2:0]) ? i_m[3] : 1'b1) : 1'b0;
    endfunction
    task automatic do_wr(input logic [5:0] a, input logic [7:0] v);
        u_link.wr(a, v);
        if (a == ADDR_FUNC_CTRL)
            f_m = v & FUNC_CTRL_STORE_MASK;
        if (a == ADDR_FUNC_SET)
            f_m = (f_m | v) & FUNC_CTRL_STORE_MASK;
        if (a == ADDR_FUNC_CLR)
            f_m = f_m & ~v;
        if (a == ADDR_IFC_CTRL)
            i_m = v;
        if ((a == ADDR_FUNC_CTRL || a == ADDR_FUNC_SET) && v[5])
            exp_pulses++;
    endtask
    task automatic do_rd(input logic [5:0] a);
        logic [7:0] v;
        u_link.rd(a, v);
        `CHK("read", exp_rd(a), v)
    endtask
    task automatic chk_out();
        repeat (2) @(posedge clk);
        `CHK("protect", ~i_m[7], prot)
        `CHK("resume", i_m[4], resume)
        `CHK("clock", exp_clk(), clk_on)
        `CHK("uart", i_m[2], uart)
        `CHK("lowpow", f_m[6], lp_n)
        `CHK("three", i_m[1], three)
        `CHK("six", i_m[0], six)
        `CHK("enc", f_m[4:3], enc)
        `CHK("term", f_m[2], term)
        `CHK("speed", f_m[1:0], speed)
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (pulse === 1'b1)
            pulses++;
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
    initial
    begin
        {rst, ext, cmp, lp_x, ser_x, uart_x} = 6'h20;
        f_m = 8'h41;
        i_m = 8'h10;
        void'($urandom(43690));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        do_rd(ADDR_IFC_CTRL);
        do_rd(ADDR_FUNC_CLR);
        chk_out();
        do_wr(ADDR_FUNC_CLR, 8'hFF);
        do_rd(ADDR_FUNC_CTRL);
        chk_out();
        do_wr(6'h08, 8'hFF);
        do_rd(6'h08);
        for (k = 0; k < 16; k++)
        begin
            do_wr(ADDR_IFC_CTRL, {1'b0, k[1:0], 5'h10});
            ext <= k[2];
            cmp <= k[3];
            repeat (8) @(posedge clk);
            `CHK("vbus", k[1] ? k[2] ^ k[0] : (k[2] ^ k[0]) & k[3], vbus)
        end
        for (k = 0; k < 80; k++)
        begin
            do_wr(6'h04 + 6'($urandom_range(0, 4)), 8'($urandom));
            {lp_x, ser_x, uart_x} <= 3'($urandom);
            @(posedge clk);
            if (uart_x)
                i_m[2] = 1'b0;
            if (ser_x)
                i_m[1:0] = 2'h0;
            if (lp_x)
                f_m[6] = 1'b1;
            {lp_x, ser_x, uart_x} <= 3'h0;
            chk_out();
            do_rd(6'h04 + 6'($urandom_range(0, 3)));
        end
        `CHK("pulses", exp_pulses, pulses)
        close_out();
    end
endmodule // tb_phy_function_interface_ctrl_regs
`default_nettype wire
